//--- speech_cmd_cfg.svh
`ifndef SPEECH_CMD_CFG_SVH
`define SPEECH_CMD_CFG_SVH
// control bytes
`define SC_STOP_BYTE 8'h18
`define SC_SKIP_BYTE 8'h19
`define SC_RESTORE_BYTE 8'h1E
`define SC_PREFIX_BYTE 8'h01
// command letters
`define SC_CMD_REINIT 8'h40
`define SC_CMD_ZAP 8'h5A
`define SC_CMD_MARK 8'h49
`define SC_CMD_QUERY 8'h3F
`define SC_CMD_MUSIC 8'h4A
`define SC_CMD_AUDIO 8'h4E
`define SC_CMD_DOWNLOAD 8'h57
`define SC_CMD_PCM 8'h23
`define SC_CMD_ADPCM 8'h25
// query arguments and number limits
`define SC_ARG_ID 10'h006
`define SC_ARG_INTG 10'h00C
`define SC_MARK_MAX 10'h063
`define SC_NUM_MAX 10'h3E7
// reply lengths
`define SC_ID_LEN 5'h08
`define SC_INTG_LEN 5'h17
// capacities in reply units of 256 bytes and 64k bytes
`define SC_BUF_UNITS 8'h08
`define SC_REC_UNITS 8'h38
// communication timeout
`define SC_TMO_SEC 10
`define SC_CLK_HZ 50000000
`define SC_TMO_CYC (`SC_TMO_SEC * `SC_CLK_HZ)
`endif

//--- speech_cmd_pkg.sv
`default_nettype none
package speech_cmd_pkg;
   typedef enum logic [1:0] {
      ST_TEXT = 2'h0,
      ST_ARG = 2'h1,
      ST_SKIP = 2'h3
   } parse_e;
   typedef enum logic [1:0] {
      TX_IDLE = 2'h0,
      TX_ID = 2'h1,
      TX_INTG = 2'h3
   } tx_e;
   typedef enum logic [1:0] {
      SYN_TEXT = 2'h0,
      SYN_CMD = 2'h1,
      SYN_MARK = 2'h2
   } syn_kind_e;
   typedef enum logic [3:0] {
      RES_OK = 4'h0,
      RES_INVALID = 4'h1,
      RES_COMM = 4'h2,
      RES_TIMEOUT = 4'h3,
      RES_ERASING = 4'h4,
      RES_ERASED = 4'h6,
      RES_WRITE = 4'h7,
      RES_NO_MEM = 4'h8,
      RES_CHECKSUM = 4'h9,
      RES_NOT_FOUND = 4'hE
   } result_e;
   typedef struct packed {
      logic store;
      logic [7:0] data;
   } rx_s;
   typedef struct packed {
      syn_kind_e kind;
      logic [7:0] data;
      logic [9:0] num;
   } syn_s;
   typedef struct packed {
      logic [1:0] mode;
      logic [7:0] punctuation_filter_setting;
      logic [7:0] formant;
      logic [7:0] pitch;
      logic [7:0] speed;
      logic [7:0] volume;
      logic [7:0] tone;
      logic [7:0] expression;
      logic dict_loaded;
      logic dict_enabled;
      logic [7:0] articulation;
      logic [7:0] reverb;
      logic [7:0] transmit_status_pin;
      logic [7:0] protocol_options;
      logic [7:0] audio_output_setting;
      logic [7:0] sleep_delay;
      logic [7:0] timeout_delay;
      logic [7:0] char_delay;
      logic [7:0] text_delay;
      logic [7:0] voice;
      logic [7:0] adc_control;
   } settings_s;
endpackage
`default_nettype wire

//--- speech_command_interpreter.sv
// What this block does
// (RULE1) stop byte abandons current work and empties the input buffer
// (RULE2) skip byte abandons current sentence, resumes at the next one
// (RULE3) stop and skip act without the command prefix byte
// (RULE4) host sends stop and skip ignoring the flow-control handshake
// (RULE5) stop and skip do nothing during real-time audio or music tones
// (RULE6) reinitialize empties the buffer and restores defaults, keeps stored data
// (RULE7) after zap, commands are read as text; earlier commands still run
// (RULE8) only the restore byte or hardware reset re-enables commands
// (RULE9) index marker numbers run 0 to 99, any count per stream
// (RULE10) a reached marker is sent to the host as one binary byte
// (RULE11) identification sends eight bytes, last two BCD revision minor then major
// (RULE12) interrogate sends one byte per setting in a fixed order
// (RULE13) capacities in 256-byte and 64k units; mode byte char/phoneme/text
// (RULE14) downloads and sound playback report an outcome code to the host
// (RULE15) outcome codes 0-4, 6-9, 14; 5 and 10-13 reserved
// (RULE16) programming data stalled over ten seconds reports timeout code
// (RULE17) only permitted commands run from greetings and dictionaries
// (RULE18) stop and skip are caught before the input buffer
`include "speech_cmd_cfg.svh"
`default_nettype none
module speech_command_interpreter #(
   parameter int unsigned TMO_CYC = `SC_TMO_CYC,
   parameter logic [47:0] ID_FACTORY = 48'h0011_2233_4455, // arbitrary
   parameter logic [7:0] REV_MINOR = 8'h00, // arbitrary
   parameter logic [7:0] REV_MAJOR = 8'h01 // arbitrary
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // host byte stream
   input wire logic i_rx_valid,
   input wire logic [7:0] i_rx_data,
   input wire logic i_rx_store,
   output logic o_rx_ready,
   // engine status
   input wire logic i_rt_audio,
   input wire logic i_tone_active,
   input wire logic i_prog_active,
   input wire speech_cmd_pkg::settings_s i_settings,
   // stream to synthesis engine
   output logic o_syn_valid,
   output speech_cmd_pkg::syn_s o_syn,
   input wire logic i_syn_ready,
   output logic o_abort,
   output logic o_skip,
   output logic o_reinit,
   output logic o_zap,
   // engine events
   input wire logic i_mark_hit,
   input wire logic [6:0] i_mark_num,
   input wire logic i_result_valid,
   input wire logic [3:0] i_result,
   // serial transmit bytes
   output logic o_tx_valid,
   output logic [7:0] o_tx_data,
   input wire logic i_tx_ready
);
   // -------------------------------------------------
   // helpers
   // -------------------------------------------------
   function automatic logic permitted(input logic [7:0] c,
                                      input logic [9:0] n);
      permitted = !(c == `SC_CMD_AUDIO || c == `SC_CMD_DOWNLOAD ||
                    c == `SC_CMD_PCM || c == `SC_CMD_ADPCM ||
                    c == `SC_CMD_QUERY ||
                    (c == `SC_CMD_MUSIC && n == 10'h000));
   endfunction

   function automatic logic [7:0] intg_byte(input logic [4:0] i,
      input speech_cmd_pkg::settings_s s);
      case (i)
         5'h00: intg_byte = {6'h00, s.mode};
         5'h01: intg_byte = s.punctuation_filter_setting;
         5'h02: intg_byte = s.formant;
         5'h03: intg_byte = s.pitch;
         5'h04: intg_byte = s.speed;
         5'h05: intg_byte = s.volume;
         5'h06: intg_byte = s.tone;
         5'h07: intg_byte = s.expression;
         5'h08: intg_byte = {7'h00, s.dict_loaded};
         5'h09: intg_byte = {7'h00, s.dict_enabled};
         5'h0A: intg_byte = `SC_BUF_UNITS;
         5'h0B: intg_byte = s.articulation;
         5'h0C: intg_byte = s.reverb;
         5'h0D: intg_byte = s.transmit_status_pin;
         5'h0E: intg_byte = s.protocol_options;
         5'h0F: intg_byte = s.audio_output_setting;
         5'h10: intg_byte = `SC_REC_UNITS;
         5'h11: intg_byte = s.sleep_delay;
         5'h12: intg_byte = s.timeout_delay;
         5'h13: intg_byte = s.char_delay;
         5'h14: intg_byte = s.text_delay;
         5'h15: intg_byte = s.voice;
         5'h16: intg_byte = s.adc_control;
         default: intg_byte = 8'h00;
      endcase
   endfunction

   function automatic logic [7:0] id_byte(input logic [4:0] i);
      case (i)
         5'h06: id_byte = REV_MINOR;
         5'h07: id_byte = REV_MAJOR;
         default: id_byte = ID_FACTORY[8'(47 - 8 * i) -: 8];
      endcase
   endfunction

   // -------------------------------------------------
   // receive, buffer and parser
   // -------------------------------------------------
   speech_cmd_pkg::rx_s buf_r [2];
   speech_cmd_pkg::rx_s buf_nxt [2];
   logic wp_r, wp_nxt, rp_r, rp_nxt;
   logic [1:0] cnt_r, cnt_nxt;
   logic rdy_r, rdy_nxt;
   speech_cmd_pkg::parse_e ps_r, ps_nxt;
   logic [9:0] num_r, num_nxt;
   logic zap_r, zap_nxt;
   logic sv_r, sv_nxt;
   speech_cmd_pkg::syn_s syn_r, syn_nxt;
   logic abort_r, abort_nxt, skip_r, skip_nxt, reinit_r, reinit_nxt;
   logic req_r, req_nxt, req_intg_r, req_intg_nxt;
   speech_cmd_pkg::tx_e ts_r;
   speech_cmd_pkg::rx_s head;
   logic ctl, quiet, pop, push;

   always_comb begin
      buf_nxt = buf_r;
      wp_nxt = wp_r;
      rp_nxt = rp_r;
      cnt_nxt = cnt_r;
      ps_nxt = ps_r;
      num_nxt = num_r;
      zap_nxt = zap_r;
      sv_nxt = sv_r && !i_syn_ready;
      syn_nxt = syn_r;
      abort_nxt = 1'b0;
      skip_nxt = 1'b0;
      reinit_nxt = 1'b0;
      req_nxt = 1'b0;
      req_intg_nxt = req_intg_r;
      head = buf_r[rp_r];
      pop = 1'b0;
      quiet = i_rt_audio || i_tone_active;
      // (RULE3) prefixless control bytes
      ctl = i_rx_valid && (i_rx_data == `SC_STOP_BYTE ||
            i_rx_data == `SC_SKIP_BYTE || i_rx_data == `SC_RESTORE_BYTE);
      // a full buffer still takes control bytes, so the host may ignore
      // the handshake for them
      // (RULE4) accepted regardless of ready
      push = i_rx_valid && !ctl && rdy_r;
      if (cnt_r != 2'h0 && (!sv_r || i_syn_ready) &&
          !(ps_r == speech_cmd_pkg::ST_ARG && head.data == `SC_CMD_QUERY
            && (ts_r != speech_cmd_pkg::TX_IDLE || req_r))) begin
         pop = 1'b1;
         rp_nxt = !rp_r;
         case (ps_r)
            speech_cmd_pkg::ST_TEXT: begin
               // (RULE7) zap turns prefix into text
               if (head.data == `SC_PREFIX_BYTE && !zap_r) begin
                  ps_nxt = speech_cmd_pkg::ST_ARG;
                  num_nxt = 10'h000;
               end else begin
                  sv_nxt = 1'b1;
                  syn_nxt = '{speech_cmd_pkg::SYN_TEXT, head.data, 10'h000};
               end
            end
            speech_cmd_pkg::ST_ARG: begin
               if (head.data >= 8'h30 && head.data <= 8'h39) begin
                  if (num_r <= 10'h063) begin
                     num_nxt = 10'(num_r * 10'd10 + 10'(head.data - 8'h30));
                  end else begin
                     num_nxt = `SC_NUM_MAX;
                  end
               end else begin
                  ps_nxt = speech_cmd_pkg::ST_TEXT;
                  // (RULE17) stored text runs permitted commands only
                  if (!head.store || permitted(head.data, num_r)) begin
                     case (head.data)
                        // (RULE6) reinit flushes and restores defaults
                        `SC_CMD_REINIT: begin
                           reinit_nxt = 1'b1;
                           pop = 1'b0;
                           cnt_nxt = 2'h0;
                           rp_nxt = wp_r;
                           sv_nxt = 1'b0;
                        end
                        `SC_CMD_ZAP: zap_nxt = 1'b1;
                        // (RULE9) markers 0 to 99 only
                        `SC_CMD_MARK: begin
                           if (num_r <= `SC_MARK_MAX) begin
                              sv_nxt = 1'b1;
                              syn_nxt = '{speech_cmd_pkg::SYN_MARK, head.data,
                                          num_r};
                           end
                        end
                        `SC_CMD_QUERY: begin
                           req_nxt = num_r == `SC_ARG_ID ||
                                     num_r == `SC_ARG_INTG;
                           req_intg_nxt = num_r == `SC_ARG_INTG;
                        end
                        default: begin
                           sv_nxt = 1'b1;
                           syn_nxt = '{speech_cmd_pkg::SYN_CMD, head.data,
                                       num_r};
                        end
                     endcase
                  end
               end
            end
            speech_cmd_pkg::ST_SKIP: begin
               if (head.data == 8'h2E || head.data == 8'h21 ||
                   head.data == 8'h3F || head.data == 8'h0D) begin
                  ps_nxt = speech_cmd_pkg::ST_TEXT;
               end
            end
            default: ps_nxt = speech_cmd_pkg::ST_TEXT;
         endcase
      end
      if (push) begin
         buf_nxt[wp_r] = '{i_rx_store, i_rx_data};
         wp_nxt = !wp_r;
      end
      if (!reinit_nxt) begin
         cnt_nxt = 2'(cnt_r + {1'b0, push} - {1'b0, pop});
      end else if (push) begin
         cnt_nxt = 2'h1;
         rp_nxt = wp_r;
      end
      // (RULE8) only the restore byte lifts zap
      if (ctl && i_rx_data == `SC_RESTORE_BYTE) begin
         zap_nxt = 1'b0;
      end
      // (RULE18) caught ahead of the buffer
      if (ctl && !quiet && !i_rx_store) begin
         // (RULE1) stop flushes buffer, synth byte and parse state
         if (i_rx_data == `SC_STOP_BYTE) begin
            abort_nxt = 1'b1;
            cnt_nxt = 2'h0;
            rp_nxt = wp_r;
            sv_nxt = 1'b0;
            ps_nxt = speech_cmd_pkg::ST_TEXT;
         // (RULE2) skip drops the sentence
         end else if (i_rx_data == `SC_SKIP_BYTE) begin
            skip_nxt = 1'b1;
            sv_nxt = 1'b0;
            ps_nxt = speech_cmd_pkg::ST_SKIP;
         end
      end
      rdy_nxt = cnt_nxt != 2'h2;
   end

   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         buf_r[0] <= '0;
         buf_r[1] <= '0;
         wp_r <= 1'b0;
         rp_r <= 1'b0;
         cnt_r <= 2'h0;
         rdy_r <= 1'b0;
         ps_r <= speech_cmd_pkg::ST_TEXT;
         num_r <= 10'h000;
         zap_r <= 1'b0;
         sv_r <= 1'b0;
         syn_r <= '0;
         abort_r <= 1'b0;
         skip_r <= 1'b0;
         reinit_r <= 1'b0;
         req_r <= 1'b0;
         req_intg_r <= 1'b0;
      end else begin
         buf_r <= buf_nxt;
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
         cnt_r <= cnt_nxt;
         rdy_r <= rdy_nxt;
         ps_r <= ps_nxt;
         num_r <= num_nxt;
         zap_r <= zap_nxt;
         sv_r <= sv_nxt;
         syn_r <= syn_nxt;
         abort_r <= abort_nxt;
         skip_r <= skip_nxt;
         reinit_r <= reinit_nxt;
         req_r <= req_nxt;
         req_intg_r <= req_intg_nxt;
      end
   end

   // -------------------------------------------------
   // transmit sequencer
   // -------------------------------------------------
   speech_cmd_pkg::tx_e ts_nxt;
   logic [4:0] idx_r, idx_nxt;
   logic mk_p_r, mk_p_nxt, rs_p_r, rs_p_nxt;
   logic [6:0] mk_r, mk_nxt;
   logic [3:0] rs_r, rs_nxt;
   logic tv_r, tv_nxt;
   logic [7:0] td_r, td_nxt;
   logic [31:0] tmo_r, tmo_nxt;
   logic reserved;

   always_comb begin
      ts_nxt = ts_r;
      idx_nxt = idx_r;
      mk_p_nxt = mk_p_r;
      mk_nxt = mk_r;
      rs_p_nxt = rs_p_r;
      rs_nxt = rs_r;
      tv_nxt = tv_r && !i_tx_ready;
      td_nxt = td_r;
      tmo_nxt = tmo_r;
      reserved = i_result == 4'h5 || (i_result >= 4'hA && i_result <= 4'hD);
      if (req_r) begin
         ts_nxt = req_intg_r ? speech_cmd_pkg::TX_INTG :
                  speech_cmd_pkg::TX_ID;
         idx_nxt = 5'h00;
      end
      if (!tv_r || i_tx_ready) begin
         case (ts_r)
            // (RULE11) eight id bytes, revision last
            speech_cmd_pkg::TX_ID: begin
               tv_nxt = 1'b1;
               td_nxt = id_byte(idx_r);
               idx_nxt = 5'(idx_r + 5'h01);
               if (idx_r == 5'(`SC_ID_LEN - 5'h01)) begin
                  ts_nxt = speech_cmd_pkg::TX_IDLE;
               end
            end
            // (RULE12) settings in fixed order
            speech_cmd_pkg::TX_INTG: begin
               tv_nxt = 1'b1;
               // (RULE13) capacities and mode byte
               td_nxt = intg_byte(idx_r, i_settings);
               idx_nxt = 5'(idx_r + 5'h01);
               if (idx_r == 5'(`SC_INTG_LEN - 5'h01)) begin
                  ts_nxt = speech_cmd_pkg::TX_IDLE;
               end
            end
            default: begin
               // (RULE10) binary marker byte
               if (mk_p_r) begin
                  tv_nxt = 1'b1;
                  td_nxt = {1'b0, mk_r};
                  mk_p_nxt = 1'b0;
               end else if (rs_p_r) begin
                  tv_nxt = 1'b1;
                  td_nxt = {4'h0, rs_r};
                  rs_p_nxt = 1'b0;
               end
            end
         endcase
      end
      // new events set after the clear, so one arriving as its flag clears is kept; a second mark while one is pending overwrites it
      if (i_mark_hit) begin
         mk_p_nxt = 1'b1;
         mk_nxt = i_mark_num;
      end
      // (RULE16) stall timer on programming data
      if (!i_prog_active || (i_rx_valid && rdy_r)) begin
         tmo_nxt = 32'h0;
      end else if (tmo_r < TMO_CYC) begin
         tmo_nxt = 32'(tmo_r + 32'h1);
         if (tmo_nxt == TMO_CYC) begin
            rs_p_nxt = 1'b1;
            rs_nxt = speech_cmd_pkg::RES_TIMEOUT;
         end
      end
      // (RULE14) outcome from engine
      // (RULE15) reserved codes never sent
      if (i_result_valid && !reserved) begin
         rs_p_nxt = 1'b1;
         rs_nxt = i_result;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         ts_r <= speech_cmd_pkg::TX_IDLE;
         idx_r <= 5'h00;
         mk_p_r <= 1'b0;
         mk_r <= 7'h00;
         rs_p_r <= 1'b0;
         rs_r <= 4'h0;
         tv_r <= 1'b0;
         td_r <= 8'h00;
         tmo_r <= 32'h0;
      end else begin
         ts_r <= ts_nxt;
         idx_r <= idx_nxt;
         mk_p_r <= mk_p_nxt;
         mk_r <= mk_nxt;
         rs_p_r <= rs_p_nxt;
         rs_r <= rs_nxt;
         tv_r <= tv_nxt;
         td_r <= td_nxt;
         tmo_r <= tmo_nxt;
      end
   end

   assign o_rx_ready = rdy_r;
   assign o_syn_valid = sv_r;
   assign o_syn = syn_r;
   assign o_abort = abort_r;
   assign o_skip = skip_r;
   assign o_reinit = reinit_r;
   assign o_zap = zap_r;
   assign o_tx_valid = tv_r;
   assign o_tx_data = td_r;

   // -------------------------------------------------
   // assertions
   // -------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);

   sequence stop_in;
      i_rx_valid && i_rx_data == `SC_STOP_BYTE && !i_rx_store &&
      !i_rt_audio && !i_tone_active;
   endsequence
   a_stop_flush: assert property ( // (RULE1)
      stop_in |=> o_abort && !o_syn_valid && cnt_r == 2'h0)
      else $error("stop did not flush");
   a_skip_sentence: assert property ( // (RULE2)
      i_rx_valid && i_rx_data == `SC_SKIP_BYTE && !i_rx_store &&
      !i_rt_audio && !i_tone_active |=> o_skip &&
      ps_r == speech_cmd_pkg::ST_SKIP)
      else $error("skip not taken");
   a_ctl_unbuffered: assert property ( // (RULE18)
      i_rx_valid && i_rx_data == `SC_STOP_BYTE |=> cnt_r <= $past(cnt_r))
      else $error("control byte entered buffer");
   a_quiet_ignore: assert property ( // (RULE5)
      (i_rt_audio || i_tone_active) |=> !o_abort && !o_skip)
      else $error("stop or skip acted while busy");
   a_zap_hold: assert property ( // (RULE8)
      o_zap && !(i_rx_valid && i_rx_data == `SC_RESTORE_BYTE) |=> o_zap)
      else $error("zap lifted without restore");
   a_zap_text: assert property ( // (RULE7)
      o_zap && ps_r == speech_cmd_pkg::ST_TEXT |=> ps_r != speech_cmd_pkg::ST_ARG)
      else $error("command parsed while zapped");
   a_marker_range: assert property ( // (RULE9)
      o_syn_valid && o_syn.kind == speech_cmd_pkg::SYN_MARK |->
      o_syn.num <= `SC_MARK_MAX)
      else $error("marker out of range");
   sequence id_start;
      req_r && !req_intg_r;
   endsequence
   a_id_length: assert property ( // (RULE11)
      id_start |=> ts_r == speech_cmd_pkg::TX_ID ##[8:300]
      (ts_r == speech_cmd_pkg::TX_IDLE && idx_r == `SC_ID_LEN))
      else $error("id reply length wrong");
   a_reinit_flush: assert property ( // (RULE6)
      o_reinit |-> cnt_r <= 2'h1 && !o_syn_valid)
      else $error("reinit left data");
   a_result_legal: assert property ( // (RULE15)
      o_tx_valid && !$past(o_tx_valid) && $past(rs_p_r) && !$past(mk_p_r) &&
      $past(ts_r) == speech_cmd_pkg::TX_IDLE |->
      !(o_tx_data == 8'h05 || (o_tx_data >= 8'h0A && o_tx_data <= 8'h0D)))
      else $error("reserved outcome sent");
endmodule
`default_nettype wire

//--- speech_host.sv
`include "speech_cmd_cfg.svh"
`default_nettype none
module speech_host (
   // clock
   input wire logic i_clk,
   // device side
   input wire logic i_rx_ready,
   input wire logic i_tx_valid,
   input wire logic [7:0] i_tx_data,
   output logic o_rx_valid,
   output logic [7:0] o_rx_data,
   output logic o_tx_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   // ------
   // host model
   // ------
   logic [7:0] got[$];
   initial begin
      o_rx_valid = 1'b0;
      o_rx_data = 8'h00;
      o_tx_ready = 1'b1;
   end
   // mid-cycle sampling sees what the next rising edge will transfer
   always @(negedge i_clk) begin
      if (i_tx_valid && o_tx_ready) begin
         got.push_back(i_tx_data);
      end
   end
   task automatic send(input logic [7:0] b);
      logic ctl;
      logic rdy;
      int n;
      ctl = b == `SC_STOP_BYTE || b == `SC_SKIP_BYTE || b == `SC_RESTORE_BYTE;
      o_rx_data = b;
      o_rx_valid = 1'b1;
      n = 0;
      do begin
         rdy = i_rx_ready;
         @(posedge i_clk);
         #1;
         n++;
      end while (!(rdy || ctl) && n < 500);
      if (!(rdy || ctl)) begin
         speech_command_interpreter_tb.check(32'h0, 32'h1);
         speech_command_interpreter_tb.test_done();
      end
   endtask
   // released bus shows inverted data, not the last byte
   task automatic idle();
      o_rx_valid = 1'b0;
      o_rx_data = ~o_rx_data;
   endtask
endmodule
`default_nettype wire

//--- speech_command_interpreter_tb.sv
`include "speech_cmd_cfg.svh"
`default_nettype none
module speech_command_interpreter_tb;
   timeunit 1ns;
   timeprecision 1ps;
   // ------
   // bench
   // ------
   localparam logic [7:0] MINOR = 8'h13; // arbitrary
   localparam logic [7:0] MAJOR = 8'h01; // arbitrary
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic rx_valid, rx_ready, rx_store = 1'b0, tx_valid, tx_ready;
   logic rt_audio = 1'b0, tone = 1'b0, prog = 1'b0, syn_ready = 1'b0;
   logic syn_valid, abort, skip, reinit, zap, mark_hit = 1'b0;
   logic res_valid = 1'b0;
   logic [7:0] rx_data, tx_data;
   logic [6:0] mark_num = 7'h00;
   logic [3:0] res = 4'h0;
   speech_cmd_pkg::settings_s settings = '0;
   speech_cmd_pkg::syn_s syn;
   speech_cmd_pkg::syn_s syn_last = '0;
   logic [7:0] syn_q[$];
   int failures = 0, check_count = 0, n_abort = 0, n_skip = 0, n_reinit = 0;
   always #10 clk = ~clk;
   always @(negedge clk) begin
      if (syn_valid === 1'b1 && syn_ready) begin
         syn_q.push_back(syn.data);
         syn_last = syn;
      end
      if (abort === 1'b1) n_abort++;
      if (skip === 1'b1) n_skip++;
      if (reinit === 1'b1) n_reinit++;
   end
   speech_command_interpreter #(.TMO_CYC(50), .REV_MINOR(MINOR),
      .REV_MAJOR(MAJOR)) DUT (.i_clk(clk), .i_rstn(rstn),
      .i_rx_valid(rx_valid), .i_rx_data(rx_data), .i_rx_store(rx_store),
      .o_rx_ready(rx_ready), .i_rt_audio(rt_audio), .i_tone_active(tone),
      .i_prog_active(prog), .i_settings(settings), .o_syn_valid(syn_valid),
      .o_syn(syn), .i_syn_ready(syn_ready), .o_abort(abort), .o_skip(skip),
      .o_reinit(reinit), .o_zap(zap), .i_mark_hit(mark_hit),
      .i_mark_num(mark_num), .i_result_valid(res_valid), .i_result(res),
      .o_tx_valid(tx_valid), .o_tx_data(tx_data), .i_tx_ready(tx_ready));
   speech_host host (.i_clk(clk), .i_rx_ready(rx_ready),
      .i_tx_valid(tx_valid), .i_tx_data(tx_data), .o_rx_valid(rx_valid),
      .o_rx_data(rx_data), .o_tx_ready(tx_ready));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: seen %0h expected %0h", $time, seen,
            exp);
      end
   endtask
   task automatic test_done();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic put(input string s);
      for (int i = 0; i < s.len(); i++) host.send(s[i]);
      host.idle();
   endtask
   task automatic cmd(input string s);
      host.send(`SC_PREFIX_BYTE);
      put(s);
      cyc(8);
   endtask
   task automatic ctl(input logic [7:0] b);
      host.send(b);
      host.idle();
      cyc(3);
   endtask
   // bounded wait; running out ends the run
   task automatic wait_tx(input int n);
      int k;
      k = 0;
      while (host.got.size() < n && k < 300) begin
         cyc(1);
         k++;
      end
      if (host.got.size() < n) begin
         check(host.got.size(), n);
         test_done();
      end
   endtask
   task automatic fill(output int n);
      syn_ready = 1'b0;
      syn_q.delete();
      n = 0;
      while (rx_ready === 1'b1 && n < 4096) begin
         host.send(8'(8'h61 + n % 26));
         n++;
      end
      host.idle();
      cyc(2);
      check(rx_ready, 1'b0);
   endtask
   task automatic t_fill();
      int n;
      fill(n);
      syn_ready = 1'b1;
      cyc(n + 40);
      check(syn_q.size(), n);
      for (int i = 0; i < n; i++) check(syn_q[i], 8'(8'h61 + i % 26));
      $display("fill done");
   endtask
   task automatic t_stop();
      int n;
      int a0;
      int s0;
      fill(n);
      a0 = n_abort;
      s0 = n_skip;
      ctl(`SC_STOP_BYTE);
      check(n_abort - a0, 1);
      syn_ready = 1'b1;
      cyc(20);
      check(syn_q.size(), 0);
      for (int k = 0; k < 3; k++) begin
         {rt_audio, tone, rx_store} = 3'h4 >> k;
         ctl(`SC_STOP_BYTE);
         ctl(`SC_SKIP_BYTE);
      end
      {rt_audio, tone, rx_store} = 3'h0;
      check(n_abort - a0, 1);
      check(n_skip - s0, 0);
      $display("stop done");
   endtask
   task automatic t_skip();
      int s0;
      s0 = n_skip;
      syn_ready = 1'b0;
      syn_q.delete();
      put("ab.");
      cyc(2);
      ctl(`SC_SKIP_BYTE);
      check(n_skip - s0, 1);
      syn_ready = 1'b1;
      put("c");
      cyc(20);
      check(syn_q.size(), 1);
      check(syn_q[0], 8'h63);
      $display("skip done");
   endtask
   task automatic t_zap();
      int r0;
      r0 = n_reinit;
      cmd("@");
      check(n_reinit - r0, 1);
      cmd("Z");
      check(zap, 1'b1);
      cmd("@");
      check(n_reinit - r0, 1);
      check(syn_q[$], `SC_CMD_REINIT);
      ctl(`SC_RESTORE_BYTE);
      check(zap, 1'b0);
      cmd("@");
      check(n_reinit - r0, 2);
      $display("zap done");
   endtask
   task automatic t_store();
      syn_q.delete();
      rx_store = 1'b1;
      cmd("5N");
      cmd("123I");
      check(syn_q.size(), 0);
      cmd("42I");
      rx_store = 1'b0;
      check(syn_q.size(), 1);
      check(syn_last,
         {speech_cmd_pkg::SYN_MARK, `SC_CMD_MARK, 10'h02A});
      $display("store done");
   endtask
   task automatic t_mark();
      for (int m = 0; m < 100; m += 33) begin
         host.got.delete();
         mark_num = 7'(m);
         mark_hit = 1'b1;
         cyc(1);
         mark_hit = 1'b0;
         wait_tx(1);
         check(host.got[0], m);
      end
      $display("mark done");
   endtask
   task automatic t_query();
      settings.pitch = 8'h32;
      settings.voice = 8'h07;
      host.got.delete();
      host.o_tx_ready = 1'b0;
      cmd("6?");
      cyc(20);
      host.o_tx_ready = 1'b1;
      wait_tx(8);
      cyc(4);
      check(host.got.size(), 8);
      check({host.got[6], host.got[7]}, {MINOR, MAJOR});
      host.got.delete();
      cmd("12?");
      wait_tx(23);
      cyc(4);
      check(host.got.size(), 23);
      check({host.got[3], host.got[21]}, 16'h3207);
      check({host.got[10], host.got[16]},
         {`SC_BUF_UNITS, `SC_REC_UNITS});
      $display("query done");
   endtask
   task automatic t_result();
      logic rsv;
      for (int c = 0; c < 15; c++) begin
         host.got.delete();
         rsv = c == 5 || (c > 9 && c < 14);
         res = 4'(c);
         res_valid = 1'b1;
         cyc(1);
         res_valid = 1'b0;
         cyc(20);
         check(host.got.size(), !rsv);
         if (!rsv) check(host.got[0], c);
      end
      $display("result done");
   endtask
   task automatic t_tmo();
      host.got.delete();
      prog = 1'b1;
      cyc(200);
      prog = 1'b0;
      check(host.got.size(), 1);
      check(host.got[0], 8'h03);
      $display("timeout done");
   endtask
   initial begin
      cyc(16);
      rstn = 1'b1;
      cyc(2);
      t_fill();
      t_stop();
      t_skip();
      t_zap();
      t_store();
      t_mark();
      t_query();
      t_result();
      t_tmo();
      test_done();
   end
endmodule
`default_nettype wire
